// ==== src/ccu_pkg.sv ====
/*
 Constants for the converter configuration upper-bit block: field
 positions, reset values and encodings. Assumes a 16-bit register
 written as a whole word by the serial configuration logic.
*/
package ccu_pkg;
    localparam int unsigned REG_W = 16;
    localparam int unsigned BIT_CAL = 15;
    localparam int unsigned BIT_PHASE = 14;
    localparam int unsigned BIT_SWING = 13;
    localparam int unsigned BIT_PATTERN = 12;
    localparam int unsigned BIT_PD_I = 11;
    localparam int unsigned BIT_PD_Q = 10;
    localparam int unsigned BIT_RSVD = 9;
    localparam logic [15:0] REG_RESET = 16'h2000;
    localparam logic [15:0] UPPER_MASK = 16'hfc00;
    localparam int unsigned DATA_W = 12;
    localparam logic [11:0] PATTERN_A = 12'h555;
    localparam logic [11:0] PATTERN_B = 12'haaa;
    localparam logic PHASE_0DEG = 1'b0;
    localparam logic PHASE_90DEG = 1'b1;
    typedef enum logic [1:0] {
        CCU_IDLE = 2'b00,
        CCU_START = 2'b01,
        CCU_BUSY = 2'b10
    } ccu_cal_state_t;
endpackage : ccu_pkg

// ==== src/ccu_sync2.sv ====
/*
 Two-flop synchroniser for one asynchronous level.
 Assumes the input comes from a pin outside core_clk_i.
*/
`timescale 1ns/10ps
module ccu_sync2 (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic async_i,
    output logic sync_o
);
    logic meta_q;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            meta_q <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : ccu_sync2

// ==== src/ccu_pattern_gen.sv ====
/*
 Fixed test pattern generator: alternates two constant words.
 Assumes the caller muxes its output onto the data lanes.
*/
`timescale 1ns/10ps
module ccu_pattern_gen #(
    parameter int unsigned DATA_W = ccu_pkg::DATA_W
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic enable_i,
    output logic [DATA_W-1:0] pattern_o,
    output logic over_range_o
);
    logic phase_q;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || !enable_i) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
        end
    end
    assign pattern_o = phase_q ? DATA_W'(ccu_pkg::PATTERN_B)
                               : DATA_W'(ccu_pkg::PATTERN_A);
    assign over_range_o = phase_q;
endmodule : ccu_pattern_gen

// ==== src/ccu_config_upper.sv ====
/*
 Upper fields of the converter configuration register: calibration
 trigger, output clock phase, swing, test pattern and channel power-down.
 Assumes the serial interface presents a whole-word write strobe on
 core_clk_i; pins are asynchronous and synchronised here.
*/
// Functional notes
// - Trigger bit rising to one starts an on-command calibration.
// - Trigger bit is never cleared by hardware; host rewrites 0 then 1.
// - Calibration request is trigger bit OR calibration pin.
// - Demuxed DDR: phase bit 0 gives 0 degrees, 1 gives 90 degrees.
// - Without demux the phase bit is ignored; 0 degrees always.
// - Swing bit sets level of data, over-range and clock lanes.
// - Pattern bit 1 drives fixed pattern on data and over-range.
// - Pattern bit 0 passes converted samples through.
// - I power-down bit: 0 runs, 1 powers the I channel down.
// - I power-down pin also powers down, even in extended control.
// - Q power-down bit: 0 runs, 1 powers the Q channel down.
// - Q power-down pin also powers down, even in extended control.
`timescale 1ns/10ps
module ccu_config_upper #(
    parameter int unsigned DATA_W = ccu_pkg::DATA_W
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    input wire logic cal_pin_i,
    input wire logic i_pd_pin_i,
    input wire logic q_pd_pin_i,
    input wire logic extended_control_mode_i,
    input wire logic demux_en_i,
    input wire logic cal_done_i,
    input wire logic [DATA_W-1:0] i_sample_i,
    input wire logic i_over_range_i,
    input wire logic [DATA_W-1:0] q_sample_i,
    input wire logic q_over_range_i,
    output logic cal_start_o,
    output logic cal_busy_o,
    output logic output_clock_phase_o,
    output logic output_swing_select_o,
    output logic [DATA_W-1:0] i_data_o,
    output logic i_over_range_o,
    output logic [DATA_W-1:0] q_data_o,
    output logic q_over_range_o,
    output logic i_channel_powerdown_o,
    output logic q_channel_powerdown_o
);
    logic [15:0] cfg_q;
    logic [15:0] cfg_d;
    logic cal_pin_s;
    logic i_pd_pin_s;
    logic q_pd_pin_s;
    logic cal_req_q;
    ccu_pkg::ccu_cal_state_t cal_st_q;
    ccu_pkg::ccu_cal_state_t cal_st_d;
    logic [DATA_W-1:0] pat_word;
    logic pat_or;

    ccu_sync2 u_sync_cal (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(cal_pin_i),
        .sync_o(cal_pin_s)
    );
    ccu_sync2 u_sync_pdi (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(i_pd_pin_i),
        .sync_o(i_pd_pin_s)
    );
    ccu_sync2 u_sync_pdq (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(q_pd_pin_i),
        .sync_o(q_pd_pin_s)
    );

    // Field views of the stored word
    wire cal_bit = cfg_q[ccu_pkg::BIT_CAL];
    wire phase_bit = cfg_q[ccu_pkg::BIT_PHASE];
    wire swing_bit = cfg_q[ccu_pkg::BIT_SWING];
    wire pattern_bit = cfg_q[ccu_pkg::BIT_PATTERN];
    wire pd_i_bit = cfg_q[ccu_pkg::BIT_PD_I];
    wire pd_q_bit = cfg_q[ccu_pkg::BIT_PD_Q];

    // Only the upper fields live here; lower bits belong elsewhere
    assign cfg_d = reg_wr_i ? (reg_wdata_i & ccu_pkg::UPPER_MASK)
                            : cfg_q;

    wire cal_req = cal_bit | cal_pin_s;
    // A held request never restarts; host must drop both first
    wire cal_edge = cal_req & ~cal_req_q;

    always_comb begin
        cal_st_d = cal_st_q;
        unique case (cal_st_q)
            ccu_pkg::CCU_IDLE: begin
                if (cal_edge) begin
                    cal_st_d = ccu_pkg::CCU_START;
                end
            end
            ccu_pkg::CCU_START: begin
                cal_st_d = ccu_pkg::CCU_BUSY;
            end
            ccu_pkg::CCU_BUSY: begin
                if (cal_done_i) begin
                    cal_st_d = ccu_pkg::CCU_IDLE;
                end
            end
            default: begin
                cal_st_d = ccu_pkg::CCU_IDLE;
            end
        endcase
    end

    // Phase only matters in demuxed DDR output
    wire phase_eff = demux_en_i ? phase_bit
                                : ccu_pkg::PHASE_0DEG;
    // Bit and pin OR; pins stay live in extended control mode
    wire pd_i_eff = pd_i_bit | i_pd_pin_s;
    wire pd_q_eff = pd_q_bit | q_pd_pin_s;
    wire unused_ecm = extended_control_mode_i;

    ccu_pattern_gen #(
        .DATA_W(DATA_W)
    ) u_pattern (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .enable_i(pattern_bit),
        .pattern_o(pat_word),
        .over_range_o(pat_or)
    );

    wire [DATA_W-1:0] i_sel = pattern_bit ? pat_word : i_sample_i;
    wire [DATA_W-1:0] q_sel = pattern_bit ? pat_word : q_sample_i;
    wire i_or_sel = pattern_bit ? pat_or : i_over_range_i;
    wire q_or_sel = pattern_bit ? pat_or : q_over_range_i;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cfg_q <= ccu_pkg::REG_RESET;
            cal_req_q <= 1'b0;
            cal_st_q <= ccu_pkg::CCU_IDLE;
        end else begin
            cfg_q <= cfg_d;
            cal_req_q <= cal_req;
            cal_st_q <= cal_st_d;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= ccu_pkg::REG_RESET;
            cal_start_o <= 1'b0;
            cal_busy_o <= 1'b0;
            output_clock_phase_o <= ccu_pkg::PHASE_0DEG;
            output_swing_select_o <= ccu_pkg::REG_RESET[ccu_pkg::BIT_SWING];
            i_channel_powerdown_o <= 1'b0;
            q_channel_powerdown_o <= 1'b0;
        end else begin
            reg_rdata_o <= cfg_d;
            cal_start_o <= (cal_st_d == ccu_pkg::CCU_START);
            cal_busy_o <= (cal_st_d != ccu_pkg::CCU_IDLE);
            output_clock_phase_o <= phase_eff;
            output_swing_select_o <= cfg_d[ccu_pkg::BIT_SWING];
            i_channel_powerdown_o <= pd_i_eff;
            q_channel_powerdown_o <= pd_q_eff;
        end
    end

    // Data path registered; reset clears lanes to zero
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            i_data_o <= '0;
            q_data_o <= '0;
            i_over_range_o <= 1'b0;
            q_over_range_o <= 1'b0;
        end else begin
            i_data_o <= i_sel;
            q_data_o <= q_sel;
            i_over_range_o <= i_or_sel;
            q_over_range_o <= q_or_sel;
        end
    end
endmodule : ccu_config_upper

// ==== sim/ccu_config_upper_monitor.sv ====
/* Assertions on the upper configuration fields.
 Bound to every ccu_config_upper instance. */
`timescale 1ns/10ps
module ccu_config_upper_monitor (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic cal_pin_i,
    input wire logic i_pd_pin_i,
    input wire logic q_pd_pin_i,
    input wire logic demux_en_i,
    input wire logic [11:0] i_sample_i,
    input wire logic cal_start_o,
    input wire logic cal_busy_o,
    input wire logic output_clock_phase_o,
    input wire logic output_swing_select_o,
    input wire logic [11:0] i_data_o,
    input wire logic i_channel_powerdown_o,
    input wire logic q_channel_powerdown_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    a_cal_bit_start: assert property ($rose(reg_rdata_o[15]) && !cal_busy_o
        && !cal_pin_i |=> cal_start_o && cal_busy_o) else $error("no start");
    a_trigger_kept: assert property (!reg_wr_i && reg_rdata_o[15]
        |=> reg_rdata_o[15]) else $error("trigger bit cleared");
    a_start_single: assert property (cal_start_o |=> !cal_start_o)
        else $error("start longer than a cycle");
    a_phase_demux: assert property (demux_en_i
        |=> output_clock_phase_o == $past(reg_rdata_o[14])) else $error("phase");
    a_phase_plain: assert property (!demux_en_i |=> !output_clock_phase_o)
        else $error("phase without demux");
    a_swing_write: assert property (reg_wr_i
        |=> output_swing_select_o == $past(reg_wdata_i[13])) else $error("swing");
    a_pattern_lane: assert property (reg_rdata_o[12] [*3] |->
        i_data_o == ccu_pkg::PATTERN_A || i_data_o == ccu_pkg::PATTERN_B)
        else $error("pattern");
    a_sample_pass: assert property (!reg_rdata_o[12] [*2]
        |=> i_data_o == $past(i_sample_i)) else $error("sample");
    a_pd_i_bit: assert property (reg_rdata_o[11] && !reg_wr_i
        |=> i_channel_powerdown_o) else $error("i power-down bit");
    a_pd_q_bit: assert property (reg_rdata_o[10] && !reg_wr_i
        |=> q_channel_powerdown_o) else $error("q power-down bit");
    a_pd_i_pin: assert property (i_pd_pin_i [*5] |-> i_channel_powerdown_o)
        else $error("i power-down pin");
    a_pd_q_pin: assert property (q_pd_pin_i [*5] |-> q_channel_powerdown_o)
        else $error("q power-down pin");
endmodule : ccu_config_upper_monitor
bind ccu_config_upper ccu_config_upper_monitor u_mon (.core_clk_i, .sys_rst_i,
    .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .cal_pin_i, .i_pd_pin_i, .q_pd_pin_i,
    .demux_en_i, .i_sample_i, .cal_start_o, .cal_busy_o, .output_clock_phase_o,
    .output_swing_select_o, .i_data_o, .i_channel_powerdown_o,
    .q_channel_powerdown_o);

// ==== sim/ccu_host_model.sv ====
/* Serial-interface host: whole-word register writes.
 Assumes the bench calls write from one process only. */
`timescale 1ns/10ps
module ccu_host_model (
    input wire logic core_clk_i,
    output logic reg_wr_o,
    output logic [15:0] reg_wdata_o
);
    initial begin
        reg_wr_o = 1'b0;
        reg_wdata_o = 16'h0000;
    end
    task automatic write(input logic [15:0] w);
        @(posedge core_clk_i);
        #1;
        reg_wr_o = 1'b1;
        reg_wdata_o = w;
        @(posedge core_clk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_wdata_o = ~w; // Stale word must not pass for valid
    endtask : write
endmodule : ccu_host_model

// ==== sim/test_converter_config_upper_bits.sv ====
/* Self-checking bench for the upper configuration fields.
 Assumes the host model and the bound checker are compiled. */
`timescale 1ns/10ps
module test_converter_config_upper_bits;
    logic clk = 1'b0, rst = 1'b1, wr, start, busy, phase, swing, ipdo, qpdo;
    logic cal_pin = 1'b0, ipd = 1'b0, qpd = 1'b0, extended_control_mode = 1'b0, demux = 1'b0;
    logic done = 1'b0, ior = 1'b0, qor = 1'b0, ioro, qoro;
    logic [11:0] isamp = 12'h123, qsamp = 12'h456;
    logic [15:0] wd, rd;
    logic [11:0] idat, qdat;
    int errors = 0, n_checks = 0;
    always #5 clk = ~clk;
    ccu_host_model HOST (.core_clk_i(clk), .reg_wr_o(wr), .reg_wdata_o(wd));
    ccu_config_upper DUT (.core_clk_i(clk), .sys_rst_i(rst), .reg_wr_i(wr),
        .reg_wdata_i(wd), .reg_rdata_o(rd), .cal_pin_i(cal_pin),
        .i_pd_pin_i(ipd), .q_pd_pin_i(qpd), .extended_control_mode_i(extended_control_mode),
        .demux_en_i(demux), .cal_done_i(done), .i_sample_i(isamp),
        .i_over_range_i(ior), .q_sample_i(qsamp), .q_over_range_i(qor),
        .cal_start_o(start), .cal_busy_o(busy), .output_clock_phase_o(phase),
        .output_swing_select_o(swing), .i_data_o(idat), .i_over_range_o(ioro),
        .q_data_o(qdat), .q_over_range_o(qoro), .i_channel_powerdown_o(ipdo),
        .q_channel_powerdown_o(qpdo));
    task chk(input string name, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
        end
    endtask : chk
    task conclude;
        $display("errors %0d checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    // Watch a bounded span for a start; finish the calibration if seen
    task automatic pulse(input logic exp);
        logic hit = 1'b0;
        repeat (8) begin
            step(1);
            if (start === 1'b1) hit = 1'b1;
        end
        chk("cal_start", 16'(hit), 16'(exp));
        if (exp && !hit) conclude();
        if (hit) begin
            done = 1'b1;
            step(1);
            done = 1'b0;
            step(1);
            chk("cal_busy", 16'(busy), 16'h0000);
        end
    endtask : pulse
    task t_reset;
        chk("reset word", rd, 16'h2000);
        HOST.write(16'h03ff);
        chk("low bits", rd, 16'h0000);
    endtask : t_reset
    task t_cal;
        HOST.write(16'h8000);
        pulse(1'b1);
        HOST.write(16'h8000);
        pulse(1'b0);
        chk("trigger", 16'(rd[15]), 16'h0001);
        HOST.write(16'h0000);
        HOST.write(16'h8000);
        pulse(1'b1);
        HOST.write(16'h0000);
        cal_pin = 1'b1;
        pulse(1'b1);
        pulse(1'b0);
        HOST.write(16'h8000);
        pulse(1'b0);
        cal_pin = 1'b0;
        HOST.write(16'h0000);
    endtask : t_cal
    task t_lanes;
        HOST.write(16'h4000);
        demux = 1'b1;
        step(2);
        chk("phase", 16'(phase), 16'h0001);
        demux = 1'b0;
        step(2);
        chk("phase", 16'(phase), 16'h0000);
        chk("swing", 16'(swing), 16'h0000);
        step(2);
        chk("i data", 16'(idat), 16'h0123);
        chk("q data", 16'(qdat), 16'h0456);
        isamp = 12'h0f0;
        qsamp = 12'h70f;
        ior = 1'b1;
        qor = 1'b1;
        step(2);
        chk("i data", 16'(idat), 16'h00f0);
        chk("q data", 16'(qdat), 16'h070f);
        chk("i or", 16'(ioro), 16'h0001);
        chk("q or", 16'(qoro), 16'h0001);
        HOST.write(16'h3000);
        chk("swing", 16'(swing), 16'h0001);
        step(3);
        chk("pattern", 16'(idat == 12'h555 || idat == 12'haaa), 16'h0001);
        chk("q pattern", 16'(qdat), 16'(idat));
        chk("i or pat", 16'(ioro), 16'(idat == 12'haaa));
        chk("q or pat", 16'(qoro), 16'(idat == 12'haaa));
        step(1);
        chk("i or pat", 16'(ioro), 16'(idat == 12'haaa));
    endtask : t_lanes
    task t_pd;
        extended_control_mode = 1'b1;
        HOST.write(16'h0800);
        step(1); // Power-down follows the stored word a cycle later
        chk("i pd", 16'(ipdo), 16'h0001);
        chk("q pd", 16'(qpdo), 16'h0000);
        HOST.write(16'h0400);
        step(1);
        chk("i pd", 16'(ipdo), 16'h0000);
        chk("q pd", 16'(qpdo), 16'h0001);
        HOST.write(16'h0000);
        ipd = 1'b1;
        step(5);
        chk("i pd pin", 16'(ipdo), 16'h0001);
        ipd = 1'b0;
        qpd = 1'b1;
        step(5);
        chk("q pd pin", 16'(qpdo), 16'h0001);
        chk("i pd", 16'(ipdo), 16'h0000);
    endtask : t_pd
    initial begin
        step(8);
        rst = 1'b0;
        t_reset();
        t_cal();
        t_lanes();
        t_pd();
        conclude();
    end
endmodule : test_converter_config_upper_bits
